// File: core/sas_pkg.sv
// Shared constants and carrier types of the successive-approximation converter sequencer.
// Assumes a single 125 MHz system clock and an active-high asynchronous reset.
package sas_pkg;

	// System clock and converter step timing.
	localparam int SAS_MCLK_PERIOD_NS = 8;
	localparam int SAS_STEP_TIME_NS = 250;
	localparam int SAS_STEP_CYCLES = (SAS_STEP_TIME_NS + SAS_MCLK_PERIOD_NS - 1) / SAS_MCLK_PERIOD_NS;
	localparam int SAS_CONV_STEPS = 102;

	// Trial schedule in converter steps, counted from the start step.
	localparam int SAS_TRIAL_FIRST = 4;
	localparam int SAS_TRIAL_LEN = 12;

	// Widths of the converter and its control fields.
	localparam int SAS_RES_BITS = 8;
	localparam int SAS_NIBBLE_BITS = 4;
	localparam int SAS_SEL_BITS = 3;
	localparam int SAS_PINS = 8;

	// Values after reset.
	localparam logic [7:0] SAS_SAR_RESET = 8'h00;
	localparam logic [3:0] SAS_PIN_FN_RESET = 4'h0;
	localparam logic [2:0] SAS_SEL_RESET = 3'h0;
	localparam logic SAS_IRQ_MODE_RESET = 1'b0;

	// Field positions of the pin function register; bit 3 covers pins 4 to 7.
	localparam int SAS_PIN_FN_BIT0 = 0;
	localparam int SAS_PIN_FN_BIT1 = 1;
	localparam int SAS_PIN_FN_BIT23 = 2;
	localparam int SAS_PIN_FN_BIT47 = 3;

	// Operations issued by the processor core, each a one-cycle pulse.
	typedef struct packed {
		logic conversion_start_op;
		logic done_flag_skip_test;
		logic irq_taken;
		logic read_result_high_op;
		logic read_result_low_op;
		logic write_pin_function_op;
		logic write_input_select_op;
		logic write_irq_mode_op;
		logic [3:0] acc;
	} sas_cpu_op_t;

	// Drive towards the reference ladder and the input multiplexer.
	typedef struct packed {
		logic [7:0] trial_code;
		logic half_lsb_down;
		logic [2:0] input_sel;
		logic mux_on;
	} sas_ladder_t;

	typedef enum logic [0:0] {
		SAS_IDLE,
		SAS_CONV
	} sas_state_t;

endpackage

// File: core/sas_sar_reg.sv
// The successive approximation register with its trial and decision steps.
// Assumes at most one of clear, set and decide is active per cycle, clear taking priority.
`timescale 1ns/1ps
`default_nettype none
module sas_sar_reg
	import sas_pkg::*;
#(
	parameter int RES_BITS = SAS_RES_BITS
)
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Trial control.
	input wire logic clear,
	input wire logic set_bit,
	input wire logic decide,
	input wire logic [2:0] bit_idx,
	input wire logic ref_below_in,
	// Register contents.
	output logic [RES_BITS-1:0] sar
);

	initial
	begin
		if (RES_BITS != 8)
			$error("sas_sar_reg: only an 8-bit register is served.");
	end

	wire logic [RES_BITS-1:0] bit_mask = RES_BITS'(1) << bit_idx;
	wire logic [RES_BITS-1:0] kept = ref_below_in ? sar : (sar & ~bit_mask);

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			sar <= SAS_SAR_RESET;
		else if (clear)
			sar <= SAS_SAR_RESET;
		else if (set_bit)
			sar <= sar | bit_mask;
		else if (decide)
			sar <= kept;
	end

endmodule
`default_nettype wire

// File: core/sas_sequencer.sv
// Successive-approximation converter sequencer facing the processor core and the analog front end.
// Assumes core operations are one-cycle pulses and the comparator output is synchronous to mclk.
// Conversion length is counted in converter steps from the step divider, not in raw clocks.
//
// Operation
// - Convert the selected input to 8 bits, high and low nibbles readable.
// - Threshold is zero for code zero, else reference/256 times code minus one half.
// - Done flag sets at conversion end; this also is the interrupt condition.
// - Interrupt mode register chooses interrupt or skip-test observation of the flag; here it only gates irq_req, the skip test works in either mode.
// - Flag clears when its interrupt is taken or the skip test skips.
// - The final result lands in the approximation register without software action.
// - Input select picks one of eight inputs after pin function setup.
// - Every conversion start clears the whole approximation register to zero.
// - Each trial sets the bit, keeps it if threshold below input, else clears.
// - Trials run from most to least significant bit, eight results form the code.
// - A conversion ends exactly 102 converter steps after start, flag then set.
// - Pin function register selects segment or analog use, written from the accumulator.
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer
	import sas_pkg::*;
#(
	parameter int STEP_CYCLES = SAS_STEP_CYCLES,
	parameter int CONV_STEPS = SAS_CONV_STEPS
)
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Processor core operations.
	input wire sas_cpu_op_t cpu_op,
	// Answers to the processor core.
	output logic [3:0] acc_out,
	output logic skip_next,
	output logic irq_req,
	output logic conversion_done_flag,
	output logic busy,
	// Analog front end.
	input wire logic ref_below_in,
	output sas_ladder_t ladder,
	output logic [SAS_PINS-1:0] pin_analog_en
);

	initial
	begin
		if (CONV_STEPS < SAS_TRIAL_FIRST + 8 * SAS_TRIAL_LEN + 1 || CONV_STEPS > 127)
			$error("sas_sequencer: CONV_STEPS cannot hold the eight trials.");
		if (STEP_CYCLES < 1 || STEP_CYCLES > 256)
			$error("sas_sequencer: STEP_CYCLES out of range.");
		if (SAS_RES_BITS != 2 * SAS_NIBBLE_BITS)
			$error("sas_sequencer: the result must split into two nibbles.");
		if (SAS_PINS != 8)
			$error("sas_sequencer: the pin function map serves eight pins.");
	end

	// Step on which trial idx sets its bit, idx being the bit position with 7 the most significant bit.
	function automatic logic [6:0] trial_set_step(input logic [2:0] idx);
		trial_set_step = 7'(SAS_TRIAL_FIRST + SAS_TRIAL_LEN * (7 - int'(idx)));
	endfunction

	// Step on which trial idx samples the comparator.
	function automatic logic [6:0] trial_decide_step(input logic [2:0] idx);
		trial_decide_step = 7'(trial_set_step(idx) + 7'(SAS_TRIAL_LEN - 1));
	endfunction

	// Control state.
	sas_state_t state;
	sas_state_t next_state;
	logic [6:0] step_cnt;
	logic [2:0] bit_idx;
	logic [3:0] pin_function_reg;
	logic [2:0] input_select_reg;
	logic irq_mode_select_reg;
	logic [SAS_RES_BITS-1:0] sar;

	// Step enable.
	logic step;
	wire logic start = cpu_op.conversion_start_op;
	wire logic converting = (state == SAS_CONV);

	sas_step_div #(
		.STEP_CYCLES(STEP_CYCLES)
	) u_div (
		.mclk(mclk),
		.rst(rst),
		.run(converting),
		.restart(start),
		.step(step)
	);

	// Trial decode.
	wire logic step_tick = converting && step;
	wire logic [6:0] set_step_now = trial_set_step(bit_idx);
	wire logic [6:0] decide_step_now = trial_decide_step(bit_idx);
	wire logic [6:0] last_step = 7'(CONV_STEPS - 1);
	wire logic at_set = step_tick && (step_cnt == set_step_now);
	wire logic at_decide = step_tick && (step_cnt == decide_step_now);
	wire logic at_end = step_tick && (step_cnt == last_step);
	wire logic conv_done = at_end && !start;

	sas_sar_reg #(
		.RES_BITS(SAS_RES_BITS)
	) u_sar (
		.mclk(mclk),
		.rst(rst),
		.clear(start),
		.set_bit(at_set),
		.decide(at_decide),
		.bit_idx(bit_idx),
		.ref_below_in(ref_below_in),
		.sar(sar)
	);

	// Sequencing.
	always_comb
	begin
		next_state = state;
		case (state)
			SAS_IDLE:
			begin
				if (start)
					next_state = SAS_CONV;
			end
			SAS_CONV:
			begin
				if (start)
					next_state = SAS_CONV;
				else if (conv_done)
					next_state = SAS_IDLE;
			end
			default:
			begin
				next_state = SAS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state <= SAS_IDLE;
		end
		else
		begin
			state <= next_state;
		end
	end

	// Operation strobes from the core.
	wire logic skip_req = cpu_op.done_flag_skip_test;
	wire logic irq_ack = cpu_op.irq_taken;
	wire logic rd_high = cpu_op.read_result_high_op;
	wire logic rd_low = cpu_op.read_result_low_op;
	wire logic wr_pin_fn = cpu_op.write_pin_function_op;
	wire logic wr_sel = cpu_op.write_input_select_op;
	wire logic wr_irq_mode = cpu_op.write_irq_mode_op;

	// The step count and bit index restart on every start, even mid-conversion.
	// A start always wins, so a restart never inherits a stale trial position.
	wire logic idx_adv = at_decide && (bit_idx != 3'h0);
	wire logic [6:0] next_step_cnt = start ? 7'h00 : (step_tick ? step_cnt + 7'h01 : step_cnt);
	wire logic [2:0] next_bit_idx = start ? 3'h7 : (idx_adv ? bit_idx - 3'h1 : bit_idx);

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			step_cnt <= 7'h00;
		end
		else
		begin
			step_cnt <= next_step_cnt;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			bit_idx <= 3'h7;
		end
		else
		begin
			bit_idx <= next_bit_idx;
		end
	end

	// Done flag: hardware set wins over any clear in the same cycle.
	wire logic skip_hit = skip_req && conversion_done_flag;
	wire logic irq_hit = irq_ack && conversion_done_flag;
	wire logic flag_clear = skip_hit || irq_hit;
	wire logic next_flag = conv_done || (conversion_done_flag && !flag_clear);

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			conversion_done_flag <= 1'b0;
		end
		else
		begin
			conversion_done_flag <= next_flag;
		end
	end

	assign skip_next = skip_hit;
	assign irq_req = conversion_done_flag && irq_mode_select_reg;
	assign busy = converting;

	// Configuration registers written from the accumulator.
	// Writes land on the edge of the strobe, so the next cycle already sees them.
	wire logic [3:0] next_pin_function = wr_pin_fn ? cpu_op.acc : pin_function_reg;
	wire logic [2:0] next_input_select = wr_sel ? cpu_op.acc[2:0] : input_select_reg;
	wire logic next_irq_mode = wr_irq_mode ? cpu_op.acc[0] : irq_mode_select_reg;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pin_function_reg <= SAS_PIN_FN_RESET;
		end
		else
		begin
			pin_function_reg <= next_pin_function;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			input_select_reg <= SAS_SEL_RESET;
		end
		else
		begin
			input_select_reg <= next_input_select;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			irq_mode_select_reg <= SAS_IRQ_MODE_RESET;
		end
		else
		begin
			irq_mode_select_reg <= next_irq_mode;
		end
	end

	// Pin function map: one bit each for pins 0 and 1, one for 2 and 3, one for 4 to 7.
	assign pin_analog_en = {{4{pin_function_reg[SAS_PIN_FN_BIT47]}},
		{2{pin_function_reg[SAS_PIN_FN_BIT23]}},
		pin_function_reg[SAS_PIN_FN_BIT1],
		pin_function_reg[SAS_PIN_FN_BIT0]};

	// Ladder drive: the trial code with a half-step offset below it for any nonzero code.
	wire logic sel_is_analog = pin_analog_en[input_select_reg];
	sas_ladder_t next_ladder;

	always_comb
	begin
		next_ladder = '0;
		next_ladder.trial_code = sar;
		next_ladder.half_lsb_down = (sar != 8'h00);
		next_ladder.input_sel = input_select_reg;
		next_ladder.mux_on = converting && sel_is_analog;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ladder <= '0;
		end
		else
		begin
			ladder <= next_ladder;
		end
	end

	// Result readout into the accumulator.
	wire logic [3:0] result_high_nibble = sar[7:4];
	wire logic [3:0] result_low_nibble = sar[3:0];
	wire logic [3:0] next_acc_out = rd_high ? result_high_nibble : (rd_low ? result_low_nibble : acc_out);

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			acc_out <= 4'h0;
		end
		else
		begin
			acc_out <= next_acc_out;
		end
	end

endmodule
`default_nettype wire

// File: core/sas_step_div.sv
// Step divider: a one-cycle enable every STEP_CYCLES clocks while running.
// Assumes the restart input is a one-cycle pulse aligned to the start of a conversion.
`timescale 1ns/1ps
`default_nettype none
module sas_step_div
	import sas_pkg::*;
#(
	parameter int STEP_CYCLES = SAS_STEP_CYCLES
)
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Control.
	input wire logic run,
	input wire logic restart,
	// Enable out.
	output logic step
);

	initial
	begin
		if (STEP_CYCLES < 1 || STEP_CYCLES > 256)
			$error("sas_step_div: STEP_CYCLES out of range.");
	end

	logic [7:0] cnt;
	wire logic at_end = (cnt == 8'(STEP_CYCLES - 1));

	assign step = run && !restart && at_end;

	// The count restarts with each conversion so every conversion spans the same steps.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			cnt <= 8'h00;
		else if (restart || !run || at_end)
			cnt <= 8'h00;
		else
			cnt <= cnt + 8'h01;
	end

endmodule
`default_nettype wire

// File: sim/sar_adc_sequencer_test.sv
// Self-checking bench of the converter sequencer.
// Assumes the front end model beside it.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_test;
	import sas_pkg::*;
	localparam int STEP = 2;
	localparam int CYC = SAS_CONV_STEPS * STEP;
	logic mclk = 1'b0;
	logic rst;
	sas_cpu_op_t cpu_op;
	logic [3:0] acc_out;
	logic skip_next, irq_req, flag, busy, ref_below_in, sk;
	sas_ladder_t ladder;
	logic [7:0] pin_en;
	logic [7:0][8:0] lv;
	int n_fail = 0;
	int checks = 0;
	int n;
	initial forever #4 mclk = ~mclk;
	sas_sequencer #(.STEP_CYCLES(STEP), .CONV_STEPS(SAS_CONV_STEPS)) dut (.mclk(mclk), .rst(rst), .cpu_op(cpu_op),
		.acc_out(acc_out), .skip_next(skip_next), .irq_req(irq_req), .conversion_done_flag(flag), .busy(busy),
		.ref_below_in(ref_below_in), .ladder(ladder), .pin_analog_en(pin_en));
	sas_front fe (.ladder(ladder), .lv(lv), .ref_below_in(ref_below_in));
	task test_done;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task go(input int k, input logic [3:0] a);
		@(negedge mclk);
		cpu_op = sas_cpu_op_t'((12'h001 << k) | {8'h00, a});
		#1 sk = skip_next;
		@(negedge mclk);
		cpu_op = '0;
	endtask
	task wait_done;
		n = 0;
		while (flag !== 1'b1 && n < 400)
		begin
			@(negedge mclk);
			n++;
		end
		if (n >= 400)
		begin
			n_fail++;
			test_done();
		end
	endtask
	function automatic logic [7:0] code(input logic [8:0] v);
		logic [7:0] c = 8'h00;
		for (int b = 7; b >= 0; b--)
			if ({c | (8'h01 << b), 1'b0} - 9'h001 < v)
				c = c | (8'h01 << b);
		return c;
	endfunction
	task conv(input int p, input logic [8:0] v, input bit rs);
		lv[p] = v;
		go(5, 4'(p));
		go(10, 4'h0);
		chk(16'(sk), 16'(p != 0));
		go(11, 4'h0);
		chk(16'(busy), 16'h1);
		if (rs)
		begin
			repeat (60) @(negedge mclk);
			go(11, 4'h0);
		end
		wait_done();
		chk(16'(n), 16'(CYC));
		chk(16'(busy), 16'h0);
		go(8, 4'h0);
		chk(16'(acc_out), 16'(code(v) >> 4));
		go(7, 4'h0);
		chk(16'(acc_out), 16'(code(v) & 8'h0f));
	endtask
	initial
	begin
		cpu_op = '0;
		rst = 1'b1;
		lv = '0;
		sk = 1'b0;
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		chk({1'b0, busy, flag, irq_req, pin_en, acc_out}, 16'h0);
		go(6, 4'h5);
		chk(16'(pin_en), 16'h000d);
		go(6, 4'hf);
		for (int p = 0; p < 8; p++)
			conv(p, 9'(p * 73 + (p == 7 ? 0 : 2)), p == 3);
		conv(1, 9'h1ff, 0);
		go(4, 4'h1);
		go(10, 4'h0);
		go(11, 4'h0);
		wait_done();
		chk(16'(irq_req), 16'h1);
		go(9, 4'h0);
		chk({flag, irq_req}, 16'h0);
		go(4, 4'h0);
		go(11, 4'h0);
		wait_done();
		chk({flag, irq_req}, 16'h2);
		go(10, 4'h0);
		chk({sk, flag}, 16'h2);
		test_done();
	end
endmodule
`default_nettype wire

// File: sim/sas_front.sv
// Comparator, ladder and input multiplexer model; levels in half code steps.
// Assumes the bench sets the pin levels.
`timescale 1ns/1ps
`default_nettype none
module sas_front
	import sas_pkg::*;
(
	// Ladder drive and pin levels.
	input wire sas_ladder_t ladder,
	input wire logic [7:0][8:0] lv,
	// Comparator out.
	output logic ref_below_in
);
	wire [8:0] thr = {ladder.trial_code, 1'b0} - {8'h00, ladder.half_lsb_down};
	wire [8:0] vin = lv[ladder.input_sel];
	assign ref_below_in = ladder.mux_on ? (thr < vin) : ~ladder.trial_code[0];
endmodule
`default_nettype wire

// File: sim/sas_seq_chk.sv
// Port checker of the converter sequencer.
// Assumes it is bound into sas_sequencer.
`timescale 1ns/1ps
`default_nettype none
module sas_seq_chk
	import sas_pkg::*;
#(
	parameter int STEP_CYCLES = SAS_STEP_CYCLES,
	parameter int CONV_STEPS = SAS_CONV_STEPS
)
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Core side.
	input wire sas_cpu_op_t cpu_op,
	input wire logic [3:0] acc_out,
	input wire logic skip_next,
	input wire logic irq_req,
	input wire logic conversion_done_flag,
	input wire logic busy,
	// Front end.
	input wire sas_ladder_t ladder,
	input wire logic [SAS_PINS-1:0] pin_analog_en
);
	localparam int CYC = CONV_STEPS * STEP_CYCLES;
	int cnt;
	logic mode;
	logic [7:0] cq;
	logic [3:0] aq;
	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			cnt <= 0;
			mode <= 1'b0;
			cq <= 8'h00;
			aq <= 4'h0;
		end
		else
		begin
			cnt <= cpu_op.conversion_start_op ? 1 : cnt + int'(busy);
			mode <= cpu_op.write_irq_mode_op ? cpu_op.acc[0] : mode;
			cq <= ladder.trial_code;
			aq <= cpu_op.acc;
		end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_start_busy: assert property (cpu_op.conversion_start_op |=> busy) else $error("no busy");
	a_start_clear: assert property (cpu_op.conversion_start_op |-> ##2 ladder.trial_code == 8'h00)
		else $error("not cleared");
	a_conv_len: assert property ($fell(busy) |-> cnt == CYC + 1) else $error("bad length");
	a_busy_bound: assert property (busy |-> cnt <= CYC) else $error("too long");
	a_done_flag: assert property ($fell(busy) |-> conversion_done_flag) else $error("no flag");
	a_irq_level: assert property (irq_req == (conversion_done_flag && mode)) else $error("irq");
	a_skip_pulse: assert property (skip_next == (cpu_op.done_flag_skip_test && conversion_done_flag))
		else $error("skip");
	a_skip_clear: assert property (skip_next && !busy |=> !conversion_done_flag) else $error("skip clr");
	a_irq_clear: assert property (cpu_op.irq_taken && conversion_done_flag && !busy |=> !conversion_done_flag)
		else $error("irq clr");
	a_read_nibble: assert property (cpu_op.read_result_high_op && !busy |=> acc_out == cq[7:4])
		else $error("read");
	a_read_low: assert property (cpu_op.read_result_low_op && !cpu_op.read_result_high_op && !busy
		|=> acc_out == cq[3:0]) else $error("read low");
	a_half_step: assert property (ladder.half_lsb_down == (ladder.trial_code != 8'h00)) else $error("half");
	a_pin_map: assert property (cpu_op.write_pin_function_op |=> pin_analog_en == {{4{aq[3]}}, {2{aq[2]}}, aq[1:0]})
		else $error("pin map");
endmodule
bind sas_sequencer sas_seq_chk #(.STEP_CYCLES(STEP_CYCLES), .CONV_STEPS(CONV_STEPS)) chk (.mclk, .rst, .cpu_op,
	.acc_out, .skip_next, .irq_req, .conversion_done_flag, .busy, .ladder, .pin_analog_en);
`default_nettype wire
